//--- core/crf_pkg.sv
// Purpose: Shared constants and types of the core register set
// Assumes: One core clock, synchronous active-high reset
// Notes:   Top pointer keeps only its low seven bits in flops

package crf_pkg;

	// ****************************************
	// Top pointer layout
	// ****************************************
	localparam logic [8:0]  TOP_FIXED     = 9'h003;
	localparam logic [6:0]  TOP_LOW_RESET = 7'h7F;
	localparam logic [6:0]  TOP_LOW_STEP  = 7'h01;
	localparam logic [15:0] TOP_RESET     = 16'h01FF;
	localparam logic [15:0] TOP_LOWEST    = 16'h0180;

	// ****************************************
	// Flag register layout
	// ****************************************
	localparam logic [7:0] FLAG_RESET = 8'hE8;
	localparam logic [2:0] FLAG_ONES  = 3'h7;
	localparam int         FLAG_H     = 4;
	localparam int         FLAG_I     = 3;
	localparam int         FLAG_N     = 2;
	localparam int         FLAG_Z     = 1;
	localparam int         FLAG_C     = 0;

	// ****************************************
	// Other reset values and context lengths
	// ****************************************
	localparam logic [7:0]  ACC_RESET   = 8'h00;
	localparam logic [7:0]  PTR_RESET   = 8'h00;
	localparam logic [15:0] FETCH_RESET = 16'h0000;
	localparam logic [2:0]  CTX_INT_LEN = 3'h5;
	localparam logic [2:0]  CTX_SUB_LEN = 3'h2;
	localparam logic [2:0]  CTX_ONE_LEN = 3'h1;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [4:0] {
		CMD_IDLE, CMD_RESULT, CMD_PREFIX, CMD_MASK_SET, CMD_MASK_CLEAR,
		CMD_CARRY_SET, CMD_CARRY_RESET, CMD_CARRY_LOAD, CMD_TOP_RESTORE,
		CMD_TOP_LOAD, CMD_FETCH_STEP, CMD_FETCH_LOAD, CMD_PUSH, CMD_POP,
		CMD_CALL, CMD_RETURN, CMD_INT_ENTRY, CMD_BREAK_ENTRY,
		CMD_SERVICE_RETURN, CMD_TEST
	} crf_cmd_t;

	typedef enum logic [1:0] {SEL_ACC, SEL_PTR, SEL_FLAGS, SEL_NONE} crf_sel_t;

	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP_ISSUE, ST_POP_TAKE} crf_state_t;

endpackage

//--- core/crf_regs.sv
// Purpose: Programmer-visible core registers, flags and stack sequencing
// Assumes: Commands come from the decoder on sys_clk; stack RAM reads asynchronously
// Notes:   Commands other than CMD_IDLE are taken only while busy is low
//
// Notes on behaviour
// - Core registers have no data address; reached only through commands.
// - Eight-bit result holder feeds and receives arithmetic and data moves.
// - Two eight-bit pointers serve as index and temporary data storage.
// - After the prefix command the next instruction uses the second pointer.
// - Interrupt entry and return never save or restore the second pointer.
// - Sixteen-bit fetch counter, low and high bytes, holds next address.
// - Flag register bits 7 to 5 read one; event-block flag is one at reset.
// - Flags push and pop as a byte; each flag is testable alone.
// - Add operations set nibble-overflow on carry from bit 3, else clear.
// - Event-block set by entry and mask set; cleared by mask clear, return.
// - Requests during event-block are held pending until it clears.
// - Clearing event-block inside a handler services pending requests at once.
// - Top-bit flag copies bit 7 of every operation result.
// - Null-result flag set when the result is zero, else cleared.
// - Overflow-borrow flag set, reset, and loaded by test, shift, rotate.
// - Top pointer upper nine bits fixed; 128-byte stack.
// - Reset and restore command load top pointer with highest stack address.
// - Push writes then decrements; pop increments then reads.
// - Top pointer wraps at both stack limits without any indication.
// - Interrupt entry pushes five bytes, low fetch byte first; return pops.
// - Call pushes two fetch counter bytes; subroutine return pops them.
// - Load command writes top pointer low seven bits; low byte readable always.

module crf_regs (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire crf_pkg::crf_cmd_t   cmd,
	input  wire crf_pkg::crf_sel_t   sel,
	input  wire logic [7:0]          dataIn,
	input  wire logic                halfCarryIn,
	input  wire logic                halfCarryUpd,
	input  wire logic                carryIn,
	input  wire logic                carryUpd,
	input  wire logic [15:0]         targetAddr,
	input  wire logic [2:0]          condSel,
	input  wire logic                condNeg,
	input  wire logic                irqReq,
	input  wire logic [7:0]          stackRdData,
	output logic [7:0]               accumulator,
	output logic [7:0]               pointerFirst,
	output logic [7:0]               pointerSecond,
	output logic [7:0]               indexSel,
	output logic [7:0]               flagRegister,
	output logic [15:0]              fetchCounter,
	output logic [15:0]              topPointer,
	output logic                     condTrue,
	output logic                     intGrant,
	output logic                     busy,
	output logic                     stackWrite,
	output logic                     stackRead,
	output logic [15:0]              stackAddr,
	output logic [7:0]               stackWrData
);
	import crf_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		crf_state_t  st;
		crf_cmd_t    op;
		crf_sel_t    sel;
		logic [2:0]  cnt;
		logic [2:0]  len;
		logic        usePtr2;
		logic [7:0]  acc;
		logic [7:0]  ptr1;
		logic [7:0]  ptr2;
		logic [7:0]  idx;
		logic [15:0] pc;
		logic [15:0] tgt;
		logic [4:0]  flags;
		logic [6:0]  top;
		logic        pend;
		logic        grant;
		logic        cond;
		logic        busy;
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} crf_regs_t;

	localparam crf_regs_t REGS_RESET = '{
		st: ST_IDLE, op: CMD_IDLE, sel: SEL_NONE, cnt: 3'h0, len: 3'h0,
		usePtr2: 1'b0, acc: ACC_RESET, ptr1: PTR_RESET, ptr2: PTR_RESET,
		idx: PTR_RESET, pc: FETCH_RESET, tgt: FETCH_RESET,
		flags: FLAG_RESET[4:0], top: TOP_LOW_RESET, pend: 1'b0, grant: 1'b0,
		cond: 1'b0, busy: 1'b0, wr: 1'b0, rd: 1'b0, addr: TOP_RESET,
		wdata: 8'h00
	};

	crf_regs_t r_q;
	crf_regs_t r_d;

	logic       take_d;
	logic [7:0] ccByte;
	logic [2:0] pos;
	logic [7:0] pushByte;

	assign ccByte = {FLAG_ONES, r_q.flags};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_d = r_q;
		r_d.wr = 1'b0;
		r_d.rd = 1'b0;
		take_d = 1'b0;
		pos = (r_q.st == ST_POP_TAKE) ? 3'(r_q.len - r_q.cnt - 3'h1) : r_q.cnt;
		// Context byte order, low fetch byte at the first location
		case (pos)
			3'h0: pushByte = r_q.pc[7:0];
			3'h1: pushByte = r_q.pc[15:8];
			3'h2: pushByte = r_q.ptr1;
			3'h3: pushByte = r_q.acc;
			default: pushByte = ccByte;
		endcase
		if (r_q.op == CMD_PUSH) begin
			case (r_q.sel)
				SEL_ACC: pushByte = r_q.acc;
				SEL_PTR: pushByte = r_q.usePtr2 ? r_q.ptr2 : r_q.ptr1;
				default: pushByte = ccByte;
			endcase
		end
		case (r_q.st)
			ST_IDLE: begin
				r_d.op = cmd;
				r_d.sel = sel;
				r_d.tgt = targetAddr;
				r_d.cnt = 3'h0;
				// Push and pop keep the prefix until their sequence ends
				if (cmd != CMD_IDLE && cmd != CMD_PREFIX && cmd != CMD_FETCH_STEP
					&& cmd != CMD_PUSH && cmd != CMD_POP) begin
					r_d.usePtr2 = 1'b0;
				end
				case (cmd)
					CMD_RESULT: begin
						case (sel)
							SEL_ACC: r_d.acc = dataIn;
							SEL_PTR: begin
								if (r_q.usePtr2) begin
									r_d.ptr2 = dataIn;
								end else begin
									r_d.ptr1 = dataIn;
								end
							end
							default: ;
						endcase
						r_d.flags[FLAG_N] = dataIn[7];
						r_d.flags[FLAG_Z] = (dataIn == 8'h00);
						if (halfCarryUpd) begin
							r_d.flags[FLAG_H] = halfCarryIn;
						end
						if (carryUpd) begin
							r_d.flags[FLAG_C] = carryIn;
						end
					end
					CMD_PREFIX: r_d.usePtr2 = 1'b1;
					CMD_MASK_SET: r_d.flags[FLAG_I] = 1'b1;
					CMD_MASK_CLEAR: r_d.flags[FLAG_I] = 1'b0;
					CMD_CARRY_SET: r_d.flags[FLAG_C] = 1'b1;
					CMD_CARRY_RESET: r_d.flags[FLAG_C] = 1'b0;
					CMD_CARRY_LOAD: r_d.flags[FLAG_C] = carryIn;
					CMD_TOP_RESTORE: r_d.top = TOP_LOW_RESET;
					CMD_TOP_LOAD: r_d.top = dataIn[6:0];
					CMD_FETCH_STEP: r_d.pc = 16'(r_q.pc + 16'h0001);
					CMD_FETCH_LOAD: r_d.pc = targetAddr;
					CMD_TEST: r_d.cond = ccByte[condSel] ^ condNeg;
					CMD_PUSH: begin
						r_d.st = ST_PUSH;
						r_d.len = CTX_ONE_LEN;
					end
					CMD_POP: begin
						r_d.st = ST_POP_ISSUE;
						r_d.len = CTX_ONE_LEN;
					end
					CMD_CALL: begin
						r_d.st = ST_PUSH;
						r_d.len = CTX_SUB_LEN;
					end
					CMD_RETURN: begin
						r_d.st = ST_POP_ISSUE;
						r_d.len = CTX_SUB_LEN;
					end
					CMD_INT_ENTRY, CMD_BREAK_ENTRY: begin
						take_d = (cmd == CMD_INT_ENTRY);
						r_d.st = ST_PUSH;
						r_d.len = CTX_INT_LEN;
					end
					CMD_SERVICE_RETURN: begin
						r_d.st = ST_POP_ISSUE;
						r_d.len = CTX_INT_LEN;
					end
					default: ;
				endcase
			end
			ST_PUSH: begin
				r_d.wr = 1'b1;
				r_d.addr = {TOP_FIXED, r_q.top};
				r_d.wdata = pushByte;
				r_d.top = 7'(r_q.top - TOP_LOW_STEP);
				r_d.cnt = 3'(r_q.cnt + 3'h1);
				if (3'(r_q.cnt + 3'h1) == r_q.len) begin
					r_d.st = ST_IDLE;
					r_d.usePtr2 = 1'b0;
					if (r_q.op != CMD_PUSH) begin
						r_d.pc = r_q.tgt;
					end
					if (r_q.op == CMD_INT_ENTRY || r_q.op == CMD_BREAK_ENTRY) begin
						r_d.flags[FLAG_I] = 1'b1;
					end
				end
			end
			ST_POP_ISSUE: begin
				r_d.top = 7'(r_q.top + TOP_LOW_STEP);
				r_d.addr = {TOP_FIXED, 7'(r_q.top + TOP_LOW_STEP)};
				r_d.rd = 1'b1;
				r_d.st = ST_POP_TAKE;
			end
			ST_POP_TAKE: begin
				if (r_q.op == CMD_POP) begin
					case (r_q.sel)
						SEL_ACC: r_d.acc = stackRdData;
						SEL_PTR: begin
							if (r_q.usePtr2) begin
								r_d.ptr2 = stackRdData;
							end else begin
								r_d.ptr1 = stackRdData;
							end
						end
						SEL_FLAGS: r_d.flags = stackRdData[4:0];
						default: ;
					endcase
				end else begin
					case (pos)
						3'h0: r_d.pc[7:0] = stackRdData;
						3'h1: r_d.pc[15:8] = stackRdData;
						3'h2: r_d.ptr1 = stackRdData;
						3'h3: r_d.acc = stackRdData;
						default: r_d.flags = stackRdData[4:0];
					endcase
				end
				r_d.cnt = 3'(r_q.cnt + 3'h1);
				if (3'(r_q.cnt + 3'h1) == r_q.len) begin
					r_d.st = ST_IDLE;
					r_d.usePtr2 = 1'b0;
					if (r_q.op == CMD_SERVICE_RETURN) begin
						r_d.flags[FLAG_I] = 1'b0;
					end
				end else begin
					r_d.st = ST_POP_ISSUE;
				end
			end
			default: r_d.st = ST_IDLE;
		endcase
		// Late request beats the clear of the same cycle
		r_d.pend = (r_q.pend & ~take_d) | irqReq;
		r_d.grant = r_d.pend & ~r_d.flags[FLAG_I] & (r_d.st == ST_IDLE);
		r_d.busy = (r_d.st != ST_IDLE);
		r_d.idx = r_d.usePtr2 ? r_d.ptr2 : r_d.ptr1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r_q <= REGS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// ****************************************
	// Outputs, visible only on ports, never in a data map
	// ****************************************
	assign accumulator   = r_q.acc;
	assign pointerFirst  = r_q.ptr1;
	assign pointerSecond = r_q.ptr2;
	assign indexSel      = r_q.idx;
	assign flagRegister  = ccByte;
	assign fetchCounter  = r_q.pc;
	assign topPointer    = {TOP_FIXED, r_q.top};
	assign condTrue      = r_q.cond;
	assign intGrant      = r_q.grant;
	assign busy          = r_q.busy;
	assign stackWrite    = r_q.wr;
	assign stackRead     = r_q.rd;
	assign stackAddr     = r_q.addr;
	assign stackWrData   = r_q.wdata;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_flag_fixed_bits: assert property (flagRegister[7:5] == FLAG_ONES)
		else $error("flag register upper bits not one");
	a_stack_upper_fixed: assert property (topPointer[15:7] == TOP_FIXED)
		else $error("top pointer upper bits changed");
	a_top_restore: assert property ((cmd == CMD_TOP_RESTORE && !busy) |=>
		topPointer == TOP_RESET)
		else $error("restore did not load highest stack address");
	a_push_then_dec: assert property (stackWrite |->
		topPointer[6:0] == 7'(stackAddr[6:0] - TOP_LOW_STEP))
		else $error("push did not decrement after write");
	a_pop_inc_read: assert property ((busy && stackRead) |->
		stackAddr == topPointer && stackAddr != $past(topPointer))
		else $error("pop read not at incremented pointer");
	a_int_five_push: assert property ((cmd == CMD_INT_ENTRY && !busy) |=>
		##1 (stackWrite && stackWrData == $past(fetchCounter[7:0], 2)
		&& stackAddr == $past(topPointer, 2)) ##0 stackWrite[*5] ##1 !stackWrite)
		else $error("interrupt entry context push wrong");
	a_second_kept: assert property ((cmd == CMD_SERVICE_RETURN && !busy) |=>
		$stable(pointerSecond)[*8])
		else $error("second pointer touched by context restore");
	a_result_flags: assert property ((cmd == CMD_RESULT && !busy) |=>
		flagRegister[FLAG_N] == $past(dataIn[7])
		&& flagRegister[FLAG_Z] == ($past(dataIn) == 8'h00))
		else $error("result flags wrong");
	a_half_carry: assert property ((cmd == CMD_RESULT && !busy && halfCarryUpd) |=>
		flagRegister[FLAG_H] == $past(halfCarryIn))
		else $error("half carry flag not updated");
	a_mask_entry: assert property ((cmd == CMD_INT_ENTRY && !busy) |=>
		##6 flagRegister[FLAG_I] && fetchCounter == $past(targetAddr, 7))
		else $error("entry did not mask and vector");
	a_pending_grant: assert property ((r_q.pend && !busy && cmd == CMD_MASK_CLEAR) |=>
		intGrant)
		else $error("pending request not granted");
	a_mask_clear: assert property ((cmd == CMD_MASK_CLEAR && !busy) |=>
		!flagRegister[FLAG_I])
		else $error("mask clear did not clear event block flag");
	a_prefix_push: assert property ((cmd == CMD_PUSH && sel == SEL_PTR && !busy
		&& r_q.usePtr2) |=> ##1 stackWrite && stackWrData == $past(pointerSecond, 2))
		else $error("prefixed push did not use second pointer");

	c_int_entry: cover property ((cmd == CMD_INT_ENTRY && !busy) ##7 !busy);
	c_service_return: cover property ((cmd == CMD_SERVICE_RETURN && !busy) ##11 !busy);
	c_call_return: cover property ((cmd == CMD_CALL && !busy) ##[3:20] (cmd == CMD_RETURN));
	c_stack_wrap: cover property (stackWrite && stackAddr == TOP_LOWEST);

endmodule

//--- verif/crf_regs_bench.sv
// Purpose: Self-checking bench for the core register set
// Assumes: Stack RAM modelled here with asynchronous read
// Notes:   Stack writes are checked against a queue of expected bytes

module crf_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import crf_pkg::*;

	logic        sys_clk, rst, halfCarryIn, halfCarryUpd, carryIn, carryUpd;
	logic        condNeg, irqReq, condTrue, intGrant, busy, stackWrite, stackRead;
	crf_cmd_t    cmd;
	crf_sel_t    sel;
	logic [7:0]  dataIn, stackRdData, accumulator, pointerFirst, pointerSecond;
	logic [7:0]  indexSel, flagRegister, stackWrData, expF, d, x, y, a, svF;
	logic [15:0] targetAddr, fetchCounter, topPointer, stackAddr, fc;
	logic [2:0]  condSel;
	logic [7:0]  stackMem [0:127];
	logic [23:0] wrQ [$];
	int          nMismatch, checksDone, nRd;

	crf_regs dut_u (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .sel(sel), .dataIn(dataIn),
		.halfCarryIn(halfCarryIn), .halfCarryUpd(halfCarryUpd), .carryIn(carryIn),
		.carryUpd(carryUpd), .targetAddr(targetAddr), .condSel(condSel), .condNeg(condNeg),
		.irqReq(irqReq), .stackRdData(stackRdData), .accumulator(accumulator),
		.pointerFirst(pointerFirst), .pointerSecond(pointerSecond), .indexSel(indexSel),
		.flagRegister(flagRegister), .fetchCounter(fetchCounter), .topPointer(topPointer),
		.condTrue(condTrue), .intGrant(intGrant), .busy(busy), .stackWrite(stackWrite),
		.stackRead(stackRead), .stackAddr(stackAddr), .stackWrData(stackWrData));

	assign stackRdData = stackMem[stackAddr[6:0]];

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Compare, command and closing tasks
	// ****************************************
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checksDone++;
		if (got !== exp) begin
			nMismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task issue(input crf_cmd_t c, input crf_sel_t s, input logic [7:0] v, input logic [15:0] t);
		int n;
		@(negedge sys_clk);
		cmd = c;
		sel = s;
		dataIn = v;
		targetAddr = t;
		@(negedge sys_clk);
		cmd = CMD_IDLE;
		n = 0;
		while (busy === 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk(24'(busy), 24'h0);
	endtask

	task res(input crf_sel_t s, input logic [7:0] v);
		issue(CMD_RESULT, s, v, 16'h0000);
		expF[2:1] = {v[7], v == 8'h00};
		if (halfCarryUpd) expF[4] = halfCarryIn;
		if (carryUpd) expF[0] = carryIn;
		chk(24'(flagRegister), 24'(expF));
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ****************************************
	// Stack RAM and write monitor
	// ****************************************
	always @(negedge sys_clk) begin
		if (stackWrite === 1'b1) begin
			stackMem[stackAddr[6:0]] <= stackWrData;
			chk({stackAddr, stackWrData}, wrQ.size() > 0 ? wrQ.pop_front() : 24'hx);
		end
		if (stackRead === 1'b1) begin
			nRd++;
		end
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		nMismatch++;
		stop_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, halfCarryIn, halfCarryUpd, carryIn, carryUpd, condNeg, irqReq} = 7'h40;
		cmd = CMD_IDLE;
		sel = SEL_NONE;
		{dataIn, targetAddr, condSel} = 27'h0;
		void'($urandom(32'hC03D));
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		expF = FLAG_RESET;
		chk(24'(flagRegister), 24'h0000E8);
		chk(24'(topPointer), 24'h0001FF);
		{halfCarryUpd, carryUpd} = 2'h3;
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 8'h00 : 8'($urandom);
			{halfCarryIn, carryIn} = 2'($urandom);
			res(SEL_ACC, d);
			chk(24'(accumulator), 24'(d));
		end
		{halfCarryUpd, carryUpd} = 2'h0;
		issue(CMD_CARRY_SET, SEL_NONE, 8'h00, 16'h0000);
		chk(24'(flagRegister[0]), 24'h1);
		issue(CMD_CARRY_RESET, SEL_NONE, 8'h00, 16'h0000);
		chk(24'(flagRegister[0]), 24'h0);
		carryIn = 1'b1;
		issue(CMD_CARRY_LOAD, SEL_NONE, 8'h00, 16'h0000);
		chk(24'(flagRegister[0]), 24'h1);
		expF[0] = 1'b1;
		for (int k = 0; k < 8; k++) begin
			condSel = 3'(k);
			condNeg = 1'($urandom);
			issue(CMD_TEST, SEL_NONE, 8'h00, 16'h0000);
			chk(24'(condTrue), 24'(expF[k] ^ condNeg));
		end
		// Pointer one, then prefixed write lands in pointer two
		x = 8'($urandom);
		y = ~x;
		res(SEL_PTR, x);
		chk(24'(indexSel), 24'(x));
		issue(CMD_PREFIX, SEL_NONE, 8'h00, 16'h0000);
		res(SEL_PTR, y);
		chk({pointerFirst, pointerSecond, indexSel}, {x, y, x});
		// Pending request held while masked
		issue(CMD_MASK_SET, SEL_NONE, 8'h00, 16'h0000);
		expF[3] = 1'b1;
		chk(24'(flagRegister), 24'(expF));
		irqReq = 1'b1;
		@(negedge sys_clk);
		irqReq = 1'b0;
		repeat (4) @(negedge sys_clk);
		chk(24'(intGrant), 24'h0);
		a = 8'($urandom);
		res(SEL_ACC, a);
		fc = 16'($urandom);
		issue(CMD_FETCH_LOAD, SEL_NONE, 8'h00, fc);
		chk(24'(fetchCounter), 24'(fc));
		issue(CMD_MASK_CLEAR, SEL_NONE, 8'h00, 16'h0000);
		expF[3] = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(24'(intGrant), 24'h1);
		svF = expF;
		wrQ = '{{16'h01FF, fc[7:0]}, {16'h01FE, fc[15:8]}, {16'h01FD, x}, {16'h01FC, a},
			{16'h01FB, svF}};
		issue(CMD_INT_ENTRY, SEL_NONE, 8'h00, 16'h8ACE);
		expF[3] = 1'b1;
		chk({fetchCounter, flagRegister}, {16'h8ACE, expF});
		chk(24'(topPointer), 24'h0001FA);
		res(SEL_ACC, ~a);
		res(SEL_PTR, 8'h3C);
		issue(CMD_SERVICE_RETURN, SEL_NONE, 8'h00, 16'h0000);
		chk({fetchCounter, flagRegister}, {fc, svF});
		chk({accumulator, pointerFirst, pointerSecond}, {a, x, y});
		chk(24'(topPointer), 24'h0001FF);
		expF = svF;
		// Call and return
		wrQ = '{{16'h01FF, fc[7:0]}, {16'h01FE, fc[15:8]}};
		issue(CMD_CALL, SEL_NONE, 8'h00, 16'h0456);
		chk({fetchCounter, topPointer[7:0]}, {16'h0456, 8'hFD});
		issue(CMD_RETURN, SEL_NONE, 8'h00, 16'h0000);
		chk({fetchCounter, topPointer[7:0]}, {fc, 8'hFF});
		// Break entry runs while masked
		issue(CMD_MASK_SET, SEL_NONE, 8'h00, 16'h0000);
		expF[3] = 1'b1;
		chk(24'(flagRegister), 24'(expF));
		wrQ = '{{16'h01FF, fc[7:0]}, {16'h01FE, fc[15:8]}, {16'h01FD, x}, {16'h01FC, a},
			{16'h01FB, expF}};
		issue(CMD_BREAK_ENTRY, SEL_NONE, 8'h00, 16'h0BAD);
		chk({fetchCounter, flagRegister}, {16'h0BAD, expF});
		issue(CMD_SERVICE_RETURN, SEL_NONE, 8'h00, 16'h0000);
		expF[3] = 1'b0;
		chk({fetchCounter, flagRegister}, {fc, expF});
		// Flags through the stack
		wrQ = '{{16'h01FF, svF}};
		issue(CMD_PUSH, SEL_FLAGS, 8'h00, 16'h0000);
		issue(CMD_CARRY_RESET, SEL_NONE, 8'h00, 16'h0000);
		issue(CMD_POP, SEL_FLAGS, 8'h00, 16'h0000);
		chk(24'(flagRegister), 24'(svF));
		// Prefixed push takes pointer two
		issue(CMD_PREFIX, SEL_NONE, 8'h00, 16'h0000);
		wrQ = '{{16'h01FF, y}};
		issue(CMD_PUSH, SEL_PTR, 8'h00, 16'h0000);
		issue(CMD_POP, SEL_PTR, 8'h00, 16'h0000);
		chk({pointerFirst, pointerSecond, indexSel}, {y, y, y});
		// Wrap at both stack limits
		issue(CMD_TOP_LOAD, SEL_NONE, 8'h00, 16'h0000);
		chk(24'(topPointer), 24'h000180);
		wrQ = '{{16'h0180, a}};
		issue(CMD_PUSH, SEL_ACC, 8'h00, 16'h0000);
		chk(24'(topPointer), 24'h0001FF);
		res(SEL_ACC, 8'h11);
		issue(CMD_POP, SEL_ACC, 8'h00, 16'h0000);
		chk({accumulator, topPointer}, {a, 16'h0180});
		issue(CMD_TOP_LOAD, SEL_NONE, 8'h42, 16'h0000);
		chk(24'(topPointer), 24'h0001C2);
		issue(CMD_TOP_RESTORE, SEL_NONE, 8'h00, 16'h0000);
		chk(24'(topPointer), 24'h0001FF);
		chk(24'(wrQ.size()), 24'h0);
		chk(24'(nRd), 24'h00000F);
		stop_test();
	end

endmodule
